// *** rtl/wss_pkg.sv ***
// shared constants, field layouts and bus carriers of the weld sequencer
package wss_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int DEBOUNCE_TIME_US = 1000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_START = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_SCHED_BASE = 12'h100;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SCHED_RESET = 32'h0000_0000;
    localparam int CTRL_SEAM_LSB = 0;
    localparam int CTRL_BEAT_LSB = 8;
    localparam int CTRL_MANUAL_BIT = 16;

    // schedule word a: squeeze, weld, percent, hold
    localparam int FA_SQZ_LSB = 24;
    localparam int FA_WELD_LSB = 16;
    localparam int FA_PCT_LSB = 8;
    localparam int FA_HOLD_LSB = 0;
    // schedule word b: off, impulses, cool, valve mode, cycle mode
    localparam int FB_OFF_LSB = 24;
    localparam int FB_IMP_LSB = 16;
    localparam int FB_COOL_LSB = 8;
    localparam int FB_VALVE_LSB = 4;
    localparam int FB_CYC_LSB = 0;

    localparam logic [7:0] SEAM_SPOT = 8'h00;
    localparam logic [7:0] SEAM_CONT = 8'h01;
    localparam logic [7:0] SEAM_NONBEAT = 8'h06;
    localparam logic [7:0] BEAT_SQZ_WELD = 8'h02;
    localparam logic [3:0] CYCLE_CHAINED = 4'h2;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } wss_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wss_axi_rsp_t;

endpackage : wss_pkg

// *** rtl/wss_debounce.sv ***
// switch debouncer: output follows input after it has held steady long enough
module wss_debounce
    import wss_pkg::*;
#(
    parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic din,
    output logic dout
);
    initial begin
        if (STABLE_CYCLES < 1 || STABLE_CYCLES > 16777215) begin
            $error("wss_debounce: STABLE_CYCLES out of range");
        end
    end

    logic samp_ff;
    logic dout_ff;
    logic [23:0] cnt_ff;
    wire differs = samp_ff != dout_ff;
    wire settled = cnt_ff == 24'(STABLE_CYCLES - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samp_ff <= 1'b0;
            dout_ff <= 1'b0;
            cnt_ff <= 24'h0;
        end else if (ce) begin
            samp_ff <= din;
            cnt_ff <= (differs && !settled) ? cnt_ff + 24'h1 : 24'h0;
            if (differs && settled) begin
                dout_ff <= samp_ff;
            end
        end
    end

    assign dout = dout_ff;

endmodule : wss_debounce

// *** rtl/wss_seq.sv ***
// weld, seam and braze sequencer with an axi4-lite register slave
// How it works
// - seam select 01 seam, 00 spot
// - continuous seam: current while initiation held
// - nonzero cool gives intermittent heat/cool seam
// - first schedule squeeze delays current, valve on
// - seam squeeze only once at initiation
// - non-beat: off count is second percent
// - non-beat: cool count is second heat time
// - non-beat: impulses repeat the heat pair
// - non-beat: chained schedules each run pattern
// - ordinary seam is beat, never chains
// - each chained schedule uses own percent
// - zero hold, zero squeeze: current stays continuous
// - beat select 02: beat in squeeze, weld
// - beat open in weld: stop, hold, release
// - held initiation completes schedule normally
// - manual braze: stage one clamps, two fires
// - manual braze: stage one open releases valve
module wss_seq
    import wss_pkg::*;
#(
    parameter int NSCHED = 16,
    parameter int DB_CYCLES = DEBOUNCE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wss_axi_req_t axi_req,
    output wss_axi_rsp_t axi_rsp,
    input wire logic line_tick,
    input wire logic init_stage1,
    input wire logic init_stage2,
    output logic weld_fire,
    output logic [7:0] weld_pct,
    output logic [3:0] valve_out
);
    initial begin
        if (NSCHED < 2 || NSCHED > 32 || (NSCHED & (NSCHED - 1)) != 0) begin
            $error("wss_seq: NSCHED must be a power of two from 2 to 32");
        end
    end

    localparam int IW = $clog2(NSCHED);

    typedef enum logic [2:0] {
        ST_IDLE, ST_SQUEEZE, ST_HEAT, ST_HEAT2, ST_COOL, ST_HOLD, ST_REARM, ST_BRAZE
    } wss_state_t;

    function automatic logic [31:0] wss_merge(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = din[8*b +: 8];
            end
        end
        return res;
    endfunction : wss_merge

    // ---------------- initiation inputs ----------------
    logic [1:0] raw_init;
    logic [1:0] db_init;
    assign raw_init = {init_stage2, init_stage1};
    for (genvar g = 0; g < 2; g++) begin : g_db
        wss_debounce #(.STABLE_CYCLES(DB_CYCLES)) u_db (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .din(raw_init[g]),
            .dout(db_init[g])
        );
    end
    wire init1 = db_init[0];
    wire init2 = db_init[1];
    wire init_on = init1 && init2;

    // mains cycle edge: counters move only on this
    logic tick_ff;
    wire line_edge = line_tick && !tick_ff;

    // ---------------- register file ----------------
    logic [31:0] ctrl_ff;
    logic [IW-1:0] start_ff;
    logic [31:0] sched_a_ff [NSCHED];
    logic [31:0] sched_b_ff [NSCHED];

    logic [11:0] aw_addr_ff;
    logic aw_have_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic w_have_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    wire aw_take = axi_req.awvalid && !aw_have_ff && !bvalid_ff;
    wire w_take = axi_req.wvalid && !w_have_ff && !bvalid_ff;
    wire wr_do = aw_have_ff && w_have_ff && !bvalid_ff;
    wire ar_take = axi_req.arvalid && !rvalid_ff;

    wire wr_sched = aw_addr_ff[11:8] == ADDR_SCHED_BASE[11:8] && {1'b0, aw_addr_ff[7:3]} < 6'(NSCHED);
    wire [IW-1:0] wr_idx = aw_addr_ff[3 +: IW];
    wire wr_ok = aw_addr_ff == ADDR_CTRL || aw_addr_ff == ADDR_START || wr_sched;

    wire rd_sched = axi_req.araddr[11:8] == ADDR_SCHED_BASE[11:8] && {1'b0, axi_req.araddr[7:3]} < 6'(NSCHED);
    wire [IW-1:0] rd_idx = axi_req.araddr[3 +: IW];

    wss_state_t state_ff;
    logic [IW-1:0] idx_ff;
    logic [7:0] cnt_ff;
    logic [7:0] rep_ff;
    logic [7:0] mode_ff;
    logic beat_ff;
    logic [31:0] status_w;
    assign status_w = {12'h0, 3'(state_ff), weld_fire, 3'h0, db_init, 3'h0, 8'(idx_ff)};

    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        if (axi_req.araddr == ADDR_CTRL) begin
            rd_word = ctrl_ff;
        end else if (axi_req.araddr == ADDR_START) begin
            rd_word = 32'(start_ff);
        end else if (axi_req.araddr == ADDR_STATUS) begin
            rd_word = status_w;
        end else if (rd_sched) begin
            rd_word = axi_req.araddr[2] ? sched_b_ff[rd_idx] : sched_a_ff[rd_idx];
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (aw_take) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= {axi_req.awaddr[11:2], 2'b00};
            end
            if (w_take) begin
                w_have_ff <= 1'b1;
                w_data_ff <= axi_req.wdata;
                w_strb_ff <= axi_req.wstrb;
            end
            if (wr_do) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && axi_req.bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RESET;
            start_ff <= '0;
            for (int i = 0; i < NSCHED; i++) begin
                sched_a_ff[i] <= SCHED_RESET;
                sched_b_ff[i] <= SCHED_RESET;
            end
        end else if (ce && wr_do) begin
            if (aw_addr_ff == ADDR_CTRL) begin
                ctrl_ff <= wss_merge(ctrl_ff, w_data_ff, w_strb_ff);
            end
            if (aw_addr_ff == ADDR_START && w_strb_ff[0]) begin
                start_ff <= w_data_ff[IW-1:0];
            end
            if (wr_sched && !aw_addr_ff[2]) begin
                sched_a_ff[wr_idx] <= wss_merge(sched_a_ff[wr_idx], w_data_ff, w_strb_ff);
            end
            if (wr_sched && aw_addr_ff[2]) begin
                sched_b_ff[wr_idx] <= wss_merge(sched_b_ff[wr_idx], w_data_ff, w_strb_ff);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_word;
                rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && axi_req.rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign axi_rsp = '{awready: !aw_have_ff && !bvalid_ff, wready: !w_have_ff && !bvalid_ff,
                       bvalid: bvalid_ff, bresp: bresp_ff, arready: !rvalid_ff,
                       rvalid: rvalid_ff, rdata: rdata_ff, rresp: rresp_ff};

    // ---------------- schedule decode ----------------
    wire [IW-1:0] nidx = idx_ff + IW'(1);
    wire [7:0] cur_sqz = sched_a_ff[idx_ff][FA_SQZ_LSB +: 8];
    wire [7:0] cur_weld = sched_a_ff[idx_ff][FA_WELD_LSB +: 8];
    wire [7:0] cur_pct = sched_a_ff[idx_ff][FA_PCT_LSB +: 8];
    wire [7:0] cur_hold = sched_a_ff[idx_ff][FA_HOLD_LSB +: 8];
    wire [7:0] cur_off = sched_b_ff[idx_ff][FB_OFF_LSB +: 8];
    wire [7:0] cur_cool = sched_b_ff[idx_ff][FB_COOL_LSB +: 8];
    wire [3:0] cur_valve = sched_b_ff[idx_ff][FB_VALVE_LSB +: 4];
    wire cur_chain = sched_b_ff[idx_ff][FB_CYC_LSB +: 4] == CYCLE_CHAINED && nidx != '0;
    wire [7:0] nxt_sched_sqz = sched_a_ff[nidx][FA_SQZ_LSB +: 8];
    wire [7:0] nxt_sched_weld = sched_a_ff[nidx][FA_WELD_LSB +: 8];
    wire [7:0] nxt_sched_imp = sched_b_ff[nidx][FB_IMP_LSB +: 8];
    wire [7:0] st_sqz = sched_a_ff[start_ff][FA_SQZ_LSB +: 8];
    wire [7:0] st_imp = sched_b_ff[start_ff][FB_IMP_LSB +: 8];

    // mode and beat option are latched at initiation so a register write
    // cannot change the character of a sequence already running
    wire is_seam = mode_ff == SEAM_CONT;
    wire is_nonbeat = mode_ff == SEAM_NONBEAT;
    wire is_spot = !is_seam && !is_nonbeat;
    wire beat_drop = beat_ff && is_spot && !init_on;
    wire cnt_done = cnt_ff == 8'h0;
    wire spot_join = is_spot && cur_hold == 8'h0 && cur_chain && nxt_sched_sqz == 8'h0;

    // ---------------- sequencer ----------------
    wss_state_t nxt_state;
    logic [IW-1:0] nxt_idx;
    logic [7:0] nxt_cnt;
    logic [7:0] nxt_rep;
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_rep = rep_ff;
        nxt_cnt = (line_edge && !cnt_done) ? cnt_ff - 8'h1 : cnt_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (ctrl_ff[CTRL_MANUAL_BIT] && init1) begin
                    nxt_state = ST_BRAZE;
                end else if (!ctrl_ff[CTRL_MANUAL_BIT] && init_on) begin
                    nxt_state = ST_SQUEEZE;
                    nxt_idx = start_ff;
                    nxt_cnt = st_sqz;
                    nxt_rep = (st_imp == 8'h0) ? 8'h1 : st_imp;
                end
            end
            ST_SQUEEZE: begin
                if (beat_drop || (is_seam && !init_on)) begin
                    nxt_state = ST_IDLE;
                end else if (cnt_done) begin
                    nxt_state = ST_HEAT;
                    nxt_cnt = cur_weld;
                end
            end
            ST_HEAT: begin
                if (beat_drop || (is_seam && !init_on)) begin
                    nxt_state = ST_HOLD;
                    nxt_cnt = cur_hold;
                end else if (is_seam) begin
                    if (cur_cool != 8'h0 && cnt_done) begin
                        nxt_state = ST_COOL;
                        nxt_cnt = cur_cool;
                    end
                end else if (cnt_done && is_nonbeat) begin
                    nxt_state = ST_HEAT2;
                    nxt_cnt = cur_cool;
                end else if (cnt_done && spot_join) begin
                    nxt_idx = nidx;
                    nxt_cnt = nxt_sched_weld;
                end else if (cnt_done) begin
                    nxt_state = ST_HOLD;
                    nxt_cnt = cur_hold;
                end
            end
            ST_HEAT2: begin
                if (cnt_done && rep_ff > 8'h1) begin
                    nxt_state = ST_HEAT;
                    nxt_rep = rep_ff - 8'h1;
                    nxt_cnt = cur_weld;
                end else if (cnt_done && cur_chain) begin
                    nxt_state = ST_HEAT;
                    nxt_idx = nidx;
                    nxt_rep = (nxt_sched_imp == 8'h0) ? 8'h1 : nxt_sched_imp;
                    nxt_cnt = nxt_sched_weld;
                end else if (cnt_done) begin
                    nxt_state = ST_HOLD;
                    nxt_cnt = cur_hold;
                end
            end
            ST_COOL: begin
                if (!init_on) begin
                    nxt_state = ST_HOLD;
                    nxt_cnt = cur_hold;
                end else if (cnt_done) begin
                    nxt_state = ST_HEAT;
                    nxt_cnt = cur_weld;
                end
            end
            ST_HOLD: begin
                if (cnt_done && is_spot && cur_chain) begin
                    nxt_state = ST_SQUEEZE;
                    nxt_idx = nidx;
                    nxt_cnt = nxt_sched_sqz;
                end else if (cnt_done) begin
                    nxt_state = ST_REARM;
                end
            end
            ST_REARM: begin
                // wait for release so a held switch does not retrigger
                if (!init_on) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_BRAZE: begin
                if (!init1) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    wire fire_w = state_ff == ST_HEAT || state_ff == ST_HEAT2 || (state_ff == ST_BRAZE && init2);
    wire valve_w = state_ff != ST_IDLE && state_ff != ST_REARM;
    wire [7:0] pct_w = (state_ff == ST_HEAT2) ? cur_off : cur_pct;

    logic fire_ff;
    logic [7:0] pct_ff;
    logic [3:0] valve_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ST_IDLE;
            idx_ff <= '0;
            cnt_ff <= 8'h0;
            rep_ff <= 8'h0;
            mode_ff <= SEAM_SPOT;
            beat_ff <= 1'b0;
            tick_ff <= 1'b0;
            fire_ff <= 1'b0;
            pct_ff <= 8'h0;
            valve_ff <= 4'h0;
        end else if (ce) begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            rep_ff <= nxt_rep;
            tick_ff <= line_tick;
            if (state_ff == ST_IDLE) begin
                mode_ff <= ctrl_ff[CTRL_SEAM_LSB +: 8];
                beat_ff <= ctrl_ff[CTRL_BEAT_LSB +: 8] == BEAT_SQZ_WELD;
            end
            fire_ff <= fire_w;
            pct_ff <= fire_w ? pct_w : 8'h0;
            valve_ff <= valve_w ? cur_valve : 4'h0;
        end
    end
    assign weld_fire = fire_ff;
    assign weld_pct = pct_ff;
    assign valve_out = valve_ff;

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_pair_end;
        ce && state_ff == ST_HEAT2 && cnt_done && rep_ff > 8'h1;
    endsequence
    sequence s_pair_restart;
        state_ff == ST_HEAT && rep_ff == $past(rep_ff) - 8'h1 && cnt_ff == $past(cur_weld);
    endsequence

    chk_seam_cont_hold: assert property (ce && state_ff == ST_HEAT && is_seam && cur_cool == 8'h0 && init_on
        |=> state_ff == ST_HEAT) else $error("continuous seam left heat while initiation held");
    chk_intermit_cool: assert property (ce && state_ff == ST_HEAT && is_seam && cur_cool != 8'h0 && cnt_done
        && init_on |=> state_ff == ST_COOL) else $error("intermittent seam skipped cool");
    chk_squeeze_valve: assert property (ce && state_ff == ST_SQUEEZE |=> valve_out == $past(cur_valve) && !weld_fire)
        else $error("squeeze without valve or with current");
    chk_seam_one_squeeze: assert property (ce && !is_spot && state_ff inside {ST_COOL, ST_HEAT2}
        |=> state_ff != ST_SQUEEZE) else $error("seam squeeze repeated");
    chk_second_pct: assert property (ce && state_ff == ST_HEAT2 |=> weld_fire && weld_pct == $past(cur_off))
        else $error("second heat used wrong percent");
    chk_heat2_follows: assert property (ce && state_ff == ST_HEAT && is_nonbeat && cnt_done
        |=> state_ff == ST_HEAT2 && cnt_ff == $past(cur_cool)) else $error("second heat not started");
    chk_pair_repeat: assert property (s_pair_end |=> s_pair_restart)
        else $error("heat pair repetition miscounted");
    chk_seam_no_chain: assert property (ce && state_ff != ST_IDLE && is_seam |=> idx_ff == $past(idx_ff))
        else $error("ordinary seam advanced schedule");
    chk_join_current: assert property (ce && state_ff == ST_HEAT && cnt_done && spot_join && !beat_drop
        |=> state_ff == ST_HEAT && idx_ff == $past(nidx) ##1 weld_fire) else $error("chain broke current");
    chk_beat_abort: assert property (ce && state_ff == ST_HEAT && beat_drop
        |=> state_ff == ST_HOLD ##1 (!ce || !weld_fire)) else $error("beat open did not stop current");
    chk_braze_fire: assert property (ce && state_ff == ST_BRAZE |=> weld_fire == $past(init2))
        else $error("braze current not following stage two");
    chk_braze_release: assert property (ce && state_ff == ST_BRAZE && !init1 |=> state_ff == ST_IDLE ##1
        (!ce || valve_out == 4'h0)) else $error("braze valve not released");
    chk_count_line: assert property (ce && !line_edge && nxt_state == state_ff && nxt_idx == idx_ff
        && state_ff != ST_IDLE |=> cnt_ff == $past(cnt_ff)) else $error("counter moved without line cycle");

endmodule : wss_seq

// *** verification/wss_operator.sv ***
// operator switch and mains line model facing the sequencer
module wss_operator #(
    parameter int TICK_DIV = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic want1,
    input wire logic want2,
    input wire logic weld_fire,
    output logic line_tick,
    output logic init_stage1,
    output logic init_stage2,
    output int fire_ticks
);
    timeunit 1ns;
    timeprecision 1ps;
    int div_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff <= 0;
            line_tick <= 1'b0;
            init_stage1 <= 1'b0;
            init_stage2 <= 1'b0;
            fire_ticks <= 0;
        end else begin
            div_ff <= (div_ff == TICK_DIV - 1) ? 0 : div_ff + 1;
            // short line period keeps runs brief; one marker per mains cycle
            line_tick <= (div_ff == 0);
            init_stage1 <= want1;
            // a two stage switch cannot close stage two without stage one
            init_stage2 <= want1 & want2;
            if (weld_fire && div_ff == 0) begin
                fire_ticks <= fire_ticks + 1;
            end
        end
    end
endmodule : wss_operator

// *** verification/wss_seq_tb.sv ***
// register-driven sequence tests for the weld sequencer
module wss_seq_tb;
    import wss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, ce, w1, w2, tick, s1, s2, fire;
    logic [7:0] pct;
    logic [3:0] valve;
    logic [31:0] d;
    logic [1:0] r;
    logic saw;
    int fticks, snap, n_mismatch, samples_checked, n2;
    wss_axi_req_t rq;
    wss_axi_rsp_t rs;
    wss_seq #(.NSCHED(16), .DB_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(rq),
        .axi_rsp(rs), .line_tick(tick), .init_stage1(s1), .init_stage2(s2), .weld_fire(fire),
        .weld_pct(pct), .valve_out(valve));
    wss_operator #(.TICK_DIV(8)) op (.aclk(aclk), .aresetn(aresetn), .want1(w1), .want2(w2),
        .weld_fire(fire), .line_tick(tick), .init_stage1(s1), .init_stage2(s2), .fire_ticks(fticks));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] dv);
        logic aw, wd, b;
        int n;
        rq.awvalid <= 1'b1;
        rq.awaddr <= a;
        rq.wvalid <= 1'b1;
        rq.wdata <= dv;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            aw = rq.awvalid & rs.awready;
            wd = rq.wvalid & rs.wready;
            b = rs.bvalid;
            r = rs.bresp;
            @(posedge aclk);
            if (aw) rq.awvalid <= 1'b0;
            if (wd) rq.wvalid <= 1'b0;
            if (b) break;
        end
        if (n == 100) begin
            n_mismatch++;
            test_done();
        end
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic ar, v;
        int n;
        rq.arvalid <= 1'b1;
        rq.araddr <= a;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            ar = rq.arvalid & rs.arready;
            v = rs.rvalid;
            d = rs.rdata;
            r = rs.rresp;
            @(posedge aclk);
            if (ar) rq.arvalid <= 1'b0;
            if (v) break;
        end
        if (n == 100) begin
            n_mismatch++;
            test_done();
        end
    endtask : rd
    task automatic wait_fire(input logic v);
        int n;
        for (n = 0; n < 800 && fire !== v; n++) @(negedge aclk);
        if (n == 800) begin
            n_mismatch++;
            test_done();
        end
        @(posedge aclk);
    endtask : wait_fire
    // follows one burst of current; bit 6 of the percent marks the second heat here
    task automatic watch(input logic [7:0] p, output logic hit, output int hi);
        logic [7:0] last;
        int n;
        hit = 1'b0;
        hi = 0;
        last = 8'h0;
        for (n = 0; n < 400 && fire === 1'b1; n++) begin
            @(negedge aclk);
            if (fire === 1'b1 && pct === p) hit = 1'b1;
            if (fire === 1'b1 && pct[6] && !last[6]) hi++;
            last = pct;
        end
        if (n == 400) begin
            n_mismatch++;
            test_done();
        end
        @(posedge aclk);
    endtask : watch
    initial begin
        rq = '0;
        rq.wstrb = 4'hf;
        rq.bready = 1'b1;
        rq.rready = 1'b1;
        aresetn = 1'b0;
        ce = 1'b1;
        w1 = 1'b0;
        w2 = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_CTRL);
        chk(d, CTRL_RESET);
        rd(12'h0f0);
        chk(d, 32'h0);
        chk(r, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h1);
        chk(r, RESP_SLVERR);
        $display("test registers done");
        // manual braze: beat 02 plus manual enable, weld and impulses 99
        wr(ADDR_CTRL, 32'h0001_0200);
        wr(ADDR_SCHED_BASE, 32'h0063_2800);
        wr(ADDR_SCHED_BASE + 12'h4, 32'h0063_0010);
        w1 <= 1'b1;
        repeat (20) @(posedge aclk);
        chk({fire, valve}, 5'h01);
        w2 <= 1'b1;
        repeat (2) @(posedge aclk);
        w2 <= 1'b0;
        repeat (20) @(posedge aclk);
        chk(fire, 1'b0);
        w2 <= 1'b1;
        wait_fire(1'b1);
        chk(pct, 8'h28);
        w2 <= 1'b0;
        wait_fire(1'b0);
        chk(valve, 4'h1);
        w1 <= 1'b0;
        repeat (20) @(posedge aclk);
        chk(valve, 4'h0);
        $display("test braze done");
        wr(ADDR_CTRL, {24'h0, SEAM_CONT});
        wr(ADDR_SCHED_BASE, 32'h0201_4001);
        wr(ADDR_SCHED_BASE + 12'h4, 32'h0000_0020);
        w1 <= 1'b1;
        w2 <= 1'b1;
        repeat (12) @(posedge aclk);
        chk({fire, valve}, 5'h02);
        wait_fire(1'b1);
        chk(pct, 8'h40);
        snap = fticks;
        repeat (200) @(posedge aclk);
        chk({fire, 1'(fticks - snap > 20)}, 2'b11);
        ce <= 1'b0;
        w1 <= 1'b0;
        w2 <= 1'b0;
        repeat (40) @(posedge aclk);
        chk(fire, 1'b1);
        ce <= 1'b1;
        wait_fire(1'b0);
        repeat (40) @(posedge aclk);
        chk(valve, 4'h0);
        $display("test seam done");
        wr(ADDR_SCHED_BASE, 32'h0a04_4001);
        wr(ADDR_SCHED_BASE + 12'h4, 32'h0000_0120);
        w1 <= 1'b1;
        w2 <= 1'b1;
        wait_fire(1'b1);
        wait_fire(1'b0);
        chk(valve, 4'h2);
        repeat (20) @(posedge aclk);
        chk(fire, 1'b1);
        w1 <= 1'b0;
        w2 <= 1'b0;
        repeat (60) @(posedge aclk);
        $display("test pulse done");
        // chained forge schedules, zero hold then zero squeeze, new heat
        wr(ADDR_CTRL, {24'h0, SEAM_SPOT});
        wr(ADDR_SCHED_BASE, 32'h0202_5f00);
        wr(ADDR_SCHED_BASE + 12'h4, 32'h0000_0012);
        wr(ADDR_SCHED_BASE + 12'h8, 32'h0002_3002);
        wr(ADDR_SCHED_BASE + 12'hc, 32'h0000_0030);
        w1 <= 1'b1;
        w2 <= 1'b1;
        wait_fire(1'b1);
        chk(pct, 8'h5f);
        watch(8'h30, saw, n2);
        chk(saw, 1'b1);
        repeat (40) @(posedge aclk);
        chk({fire, valve}, 5'h00);
        w1 <= 1'b0;
        w2 <= 1'b0;
        repeat (20) @(posedge aclk);
        $display("test chain done");
        wr(ADDR_CTRL, {24'h0, SEAM_NONBEAT});
        wr(ADDR_START, 32'h2);
        wr(ADDR_SCHED_BASE + 12'h10, 32'h0101_2001);
        wr(ADDR_SCHED_BASE + 12'h14, 32'h5002_0112);
        wr(ADDR_SCHED_BASE + 12'h18, 32'h0a01_2101);
        wr(ADDR_SCHED_BASE + 12'h1c, 32'h5101_0110);
        w1 <= 1'b1;
        w2 <= 1'b1;
        wait_fire(1'b1);
        watch(8'h51, saw, n2);
        chk(saw, 1'b1);
        chk(n2, 3);
        w1 <= 1'b0;
        w2 <= 1'b0;
        repeat (40) @(posedge aclk);
        $display("test nonbeat done");
        wr(ADDR_CTRL, 32'h0000_0200);
        wr(ADDR_SCHED_BASE + 12'h10, 32'h0163_3005);
        wr(ADDR_SCHED_BASE + 12'h14, 32'h0000_0010);
        w1 <= 1'b1;
        w2 <= 1'b1;
        wait_fire(1'b1);
        w1 <= 1'b0;
        w2 <= 1'b0;
        repeat (15) @(posedge aclk);
        chk({fire, valve}, 5'h01);
        repeat (60) @(posedge aclk);
        chk(valve, 4'h0);
        $display("test beat done");
        test_done();
    end
endmodule : wss_seq_tb
